/* File: hdl/pdr_i2c_link.sv */
`timescale 1ns/1ps
`default_nettype none
module pdr_i2c_link (
    // Link clock and resets
    input  wire logic        scl,
    input  wire logic        rstN,
    input  wire logic        frameRstN,
    // Data pin
    input  wire logic        sdaIn,
    output logic             sdaOe,
    // Decoded writes
    output logic [15:0]      pdData,
    output logic             pdWrTgl,
    output logic             swRstTgl
);

    logic [3:0]  bitCnt_q;
    logic [2:0]  byteCnt_q;
    logic [7:0]  shift_q;
    logic        addrHit_q;
    logic [7:0]  ptr_q;
    logic [7:0]  msb_q;
    logic        sdaOe_q;
    logic [15:0] pdData_q;
    logic        pdWrTgl_q;
    logic        swRstTgl_q;
    logic        byteDone;
    logic [15:0] word;
    logic        isSwRst;
    logic        isPdWr;
    logic        ackNow;

    assign byteDone = bitCnt_q == pdr_pkg::BIT_ACK;
    assign word     = {msb_q, shift_q};
    assign isSwRst  = byteDone && addrHit_q && byteCnt_q == pdr_pkg::BYTE_LSB
                      && ptr_q == pdr_pkg::PTR_SOFT_RESET
                      && word == pdr_pkg::SOFT_RESET_KEY;
    assign isPdWr   = byteDone && addrHit_q && byteCnt_q == pdr_pkg::BYTE_LSB
                      && ptr_q == pdr_pkg::PTR_PD_CTRL;

    always_comb
    begin
        case (byteCnt_q)
            pdr_pkg::BYTE_ADDR: ackNow = shift_q[7:1] == pdr_pkg::DEV_ADDR && !shift_q[0];
            pdr_pkg::BYTE_PTR:  ackNow = addrHit_q;
            pdr_pkg::BYTE_MSB:  ackNow = addrHit_q;
            pdr_pkg::BYTE_LSB:  ackNow = addrHit_q && !isSwRst;
            default:            ackNow = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Bit and byte counting on rising SCL
    // ------------------------------------------------------------
    always_ff @(posedge scl or negedge frameRstN)
    begin
        if (!frameRstN)
        begin
            bitCnt_q  <= 4'h0;
            byteCnt_q <= 3'h0;
            shift_q   <= 8'h00;
        end
        else if (byteDone)
        begin
            bitCnt_q <= 4'h0;
            if (byteCnt_q != pdr_pkg::BYTE_OVER)
                byteCnt_q <= byteCnt_q + 3'h1;
        end
        else
        begin
            shift_q  <= {shift_q[6:0], sdaIn};
            bitCnt_q <= bitCnt_q + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // Acknowledge and header capture on falling SCL
    // ------------------------------------------------------------
    always_ff @(negedge scl or negedge frameRstN)
    begin
        if (!frameRstN)
        begin
            sdaOe_q   <= 1'b0;
            addrHit_q <= 1'b0;
            ptr_q     <= 8'h00;
            msb_q     <= 8'h00;
        end
        else
        begin
            sdaOe_q <= byteDone && ackNow;
            if (byteDone && byteCnt_q == pdr_pkg::BYTE_ADDR)
                addrHit_q <= ackNow;
            if (byteDone && byteCnt_q == pdr_pkg::BYTE_PTR)
                ptr_q <= shift_q;
            if (byteDone && byteCnt_q == pdr_pkg::BYTE_MSB)
                msb_q <= shift_q;
        end
    end

    // ------------------------------------------------------------
    // Completed writes, survive frame resets
    // ------------------------------------------------------------
    always_ff @(negedge scl or negedge rstN)
    begin
        if (!rstN)
        begin
            pdData_q   <= pdr_pkg::PD_CTRL_RESET;
            pdWrTgl_q  <= 1'b0;
            swRstTgl_q <= 1'b0;
        end
        else if (isSwRst)
            swRstTgl_q <= !swRstTgl_q;
        else if (isPdWr)
        begin
            pdData_q  <= word;
            pdWrTgl_q <= !pdWrTgl_q;
        end
    end

    assign sdaOe    = sdaOe_q;
    assign pdData   = pdData_q;
    assign pdWrTgl  = pdWrTgl_q;
    assign swRstTgl = swRstTgl_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking linkCk @(negedge scl); endclocking
    default disable iff (!rstN);

    no_ack_reset_a: assert property (isSwRst |=> !sdaOe_q)
        else $error("soft reset byte was acknowledged");
    reset_edge_a: assert property (isSwRst |=> swRstTgl_q != $past(swRstTgl_q))
        else $error("soft reset not started at last falling edge");
    pd_pointer_a: assert property (isPdWr |=> pdWrTgl_q != $past(pdWrTgl_q)
                                   && pdData_q == $past(word))
        else $error("power-down write not captured");

endmodule // pdr_i2c_link
`default_nettype wire

/* File: hdl/pdr_pkg.sv */
// Behaviour
// - ADC off when no pin is analog input
// - Temperature read powers the ADC up
// - Global shutdown powers down DACs, reference, ADC
// - Shutdown overrides reference and sleep bits
// - Reference enable defaults off, 1 powers up
// - Sleep bit acts only on DAC channels
// - Key 0x0DAC at pointer 0x0F resets
// - Any reset restores registers and pin defaults
// - Soft reset starts at last data falling edge
// - Soft reset data byte is not acknowledged
// - Reset pin falling edge starts reset
// - Reset completes within 100 microseconds
// - Pointer 0x0B reaches power-down register
// - Sleeping DAC floats, wakes with old code
package pdr_pkg;

    // ------------------------------------------------------------
    // Pointers, keys and register layout
    // ------------------------------------------------------------
    localparam logic [7:0]  PTR_PD_CTRL    = 8'h0B;
    localparam logic [7:0]  PTR_SOFT_RESET = 8'h0F;
    localparam logic [15:0] SOFT_RESET_KEY = 16'h0DAC;
    localparam logic [15:0] PD_CTRL_RESET  = 16'h0000;
    localparam logic [15:0] PD_WRITE_MASK  = 16'h06FF;
    localparam int          SHUTDOWN_BIT   = 10;
    localparam int          REF_EN_BIT     = 9;
    localparam int          SLEEP_MSB      = 7;
    localparam int          SLEEP_LSB      = 0;
    localparam logic [6:0]  DEV_ADDR       = 7'h10;

    // ------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------
    localparam logic [3:0]  BIT_ACK        = 4'h8;
    localparam logic [2:0]  BYTE_ADDR      = 3'h0;
    localparam logic [2:0]  BYTE_PTR       = 3'h1;
    localparam logic [2:0]  BYTE_MSB       = 3'h2;
    localparam logic [2:0]  BYTE_LSB       = 3'h3;
    localparam logic [2:0]  BYTE_OVER      = 3'h4;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int          CLK_MHZ        = 50;
    localparam int          RESET_TIME_US  = 100;
    localparam int          RESET_CYCLES   = RESET_TIME_US * CLK_MHZ;

    typedef enum logic
    {
        SEQ_RUN   = 1'b0,
        SEQ_RESET = 1'b1
    } pdr_seq_t;

endpackage

/* File: hdl/pdr_power_reset_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module pdr_power_reset_ctrl #(
    parameter int unsigned RESET_CYCLES = pdr_pkg::RESET_CYCLES
) (
    // System clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Serial link
    input  wire logic        scl,
    input  wire logic        sdaIn,
    output logic             sdaOut,
    output logic             sdaOe,
    // Hardware reset pin
    input  wire logic        resetPinN,
    // Pin configuration
    input  wire logic [7:0]  dacChannelMask,
    input  wire logic [7:0]  adcChannelMask,
    input  wire logic        tempReadReq,
    // Power states
    output logic [15:0]      pdCtrl,
    output logic [7:0]       dacSleep,
    output logic [7:0]       dacDriveEn,
    output logic             refEnable,
    output logic             adcPowerUp,
    output logic             resetBusy
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [1:0]        sclSync_q;
    logic [2:0]        sdaSync_q;
    logic [2:0]        pinSync_q;
    logic [2:0]        wrSync_q;
    logic [2:0]        rstSync_q;
    logic              frameRst_q;
    logic              frameRstN;
    logic [15:0]       pdData;
    logic              pdWrTgl;
    logic              swRstTgl;
    logic              linkSdaOe;
    logic              sdaOut_q;
    logic              wrEdge;
    logic              swEdge;
    logic              hwFall;
    logic              resetting;
    logic              applyCause;
    pdr_pkg::pdr_seq_t seq_q;
    pdr_pkg::pdr_seq_t seq_d;
    logic [12:0]       seqCnt_q;
    logic [15:0]       pdCtrl_q;
    logic [7:0]        dacSleep_q;
    logic [7:0]        dacDriveEn_q;
    logic              refEnable_q;
    logic              adcPowerUp_q;
    logic              shutdown;
    logic [7:0]        sleepBits;
    logic [7:0]        sleepNow;

    localparam logic [12:0] LAST_CNT = 13'(RESET_CYCLES - 1);

    function automatic logic changed(input logic newV, input logic oldV);
        changed = newV ^ oldV;
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclSync_q <= 2'h0;
            sdaSync_q <= 3'h7;
            pinSync_q <= 3'h7;
        end
        else
        begin
            sclSync_q <= {sclSync_q[0], scl};
            sdaSync_q <= {sdaSync_q[1:0], sdaIn};
            pinSync_q <= {pinSync_q[1:0], resetPinN};
        end
    end

    // ------------------------------------------------------------
    // Toggle crossings from the link
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wrSync_q  <= 3'h0;
            rstSync_q <= 3'h0;
        end
        else
        begin
            wrSync_q  <= {wrSync_q[1:0], pdWrTgl};
            rstSync_q <= {rstSync_q[1:0], swRstTgl};
        end
    end

    assign wrEdge = changed(wrSync_q[2], wrSync_q[1]);
    assign swEdge = changed(rstSync_q[2], rstSync_q[1]);
    assign hwFall = changed(pinSync_q[2], pinSync_q[1]) && pinSync_q[2];

    // ------------------------------------------------------------
    // Start and stop detection, link frame reset
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            frameRst_q <= 1'b1;
        else
            frameRst_q <= resetting
                          || (sclSync_q[1] && changed(sdaSync_q[2], sdaSync_q[1]));
    end

    assign frameRstN = rst_n && !frameRst_q;

    pdr_i2c_link u_link (
        .scl       (scl),
        .rstN      (rst_n),
        .frameRstN (frameRstN),
        .sdaIn     (sdaIn),
        .sdaOe     (linkSdaOe),
        .pdData    (pdData),
        .pdWrTgl   (pdWrTgl),
        .swRstTgl  (swRstTgl)
    );

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            sdaOut_q <= 1'b0;
        else
            sdaOut_q <= 1'b0;
    end

    // ------------------------------------------------------------
    // Reset sequencer
    // ------------------------------------------------------------
    assign resetting = seq_q == pdr_pkg::SEQ_RESET;

    always_comb
    begin
        case (seq_q)
            pdr_pkg::SEQ_RUN:
                seq_d = (hwFall || swEdge) ? pdr_pkg::SEQ_RESET
                                           : pdr_pkg::SEQ_RUN;
            pdr_pkg::SEQ_RESET:
                seq_d = (seqCnt_q == LAST_CNT) ? pdr_pkg::SEQ_RUN
                                               : pdr_pkg::SEQ_RESET;
            default:
                seq_d = pdr_pkg::SEQ_RUN;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            seq_q <= pdr_pkg::SEQ_RUN;
        else
            seq_q <= seq_d;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            seqCnt_q <= 13'h0000;
        else if (resetting)
            seqCnt_q <= seqCnt_q + 13'h0001;
        else
            seqCnt_q <= 13'h0000;
    end

    // ------------------------------------------------------------
    // Power-down and reference control register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            pdCtrl_q <= pdr_pkg::PD_CTRL_RESET;
        else if (resetting)
            pdCtrl_q <= pdr_pkg::PD_CTRL_RESET;
        else if (wrEdge)
            pdCtrl_q <= pdData & pdr_pkg::PD_WRITE_MASK;
    end

    assign applyCause = wrEdge || resetting;

    // ------------------------------------------------------------
    // Power states
    // ------------------------------------------------------------
    assign shutdown  = pdCtrl_q[pdr_pkg::SHUTDOWN_BIT];
    assign sleepBits = pdCtrl_q[pdr_pkg::SLEEP_MSB:pdr_pkg::SLEEP_LSB];
    assign sleepNow  = shutdown ? 8'hFF : (sleepBits & dacChannelMask);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dacSleep_q   <= 8'h00;
            dacDriveEn_q <= 8'h00;
        end
        else
        begin
            dacSleep_q   <= sleepNow;
            dacDriveEn_q <= resetting ? 8'h00 : (dacChannelMask & ~sleepNow);
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            refEnable_q <= 1'b0;
        else
            refEnable_q <= !shutdown && pdCtrl_q[pdr_pkg::REF_EN_BIT];
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            adcPowerUp_q <= 1'b0;
        else
            adcPowerUp_q <= !shutdown && ((|adcChannelMask) || tempReadReq);
    end

    assign sdaOut     = sdaOut_q;
    assign sdaOe      = linkSdaOe;
    assign pdCtrl     = pdCtrl_q;
    assign dacSleep   = dacSleep_q;
    assign dacDriveEn = dacDriveEn_q;
    assign refEnable  = refEnable_q;
    assign adcPowerUp = adcPowerUp_q;
    assign resetBusy  = resetting;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking sysCk @(posedge clk); endclocking
    default disable iff (!rst_n);

    shutdown_dac_a: assert property (shutdown |=> dacSleep_q == 8'hFF)
        else $error("DACs awake under shutdown");
    shutdown_ana_a: assert property (shutdown |=> !refEnable_q && !adcPowerUp_q)
        else $error("reference or ADC awake under shutdown");
    sleep_follow_a: assert property (!shutdown |=> dacSleep_q
                                     == $past(sleepBits & dacChannelMask))
        else $error("sleep bits not obeyed");
    sleep_dac_only_a: assert property (!shutdown && dacChannelMask == 8'h00
                                       |=> dacSleep_q == 8'h00)
        else $error("non-DAC channel put to sleep");
    ref_enable_a: assert property (!shutdown && pdCtrl_q[pdr_pkg::REF_EN_BIT]
                                   |=> refEnable_q)
        else $error("reference not enabled");
    adc_auto_a: assert property (adcChannelMask == 8'h00 && !tempReadReq
                                 |=> !adcPowerUp_q)
        else $error("ADC powered with no analog input");
    temp_wake_a: assert property (!shutdown && tempReadReq |=> adcPowerUp_q)
        else $error("ADC not woken for temperature read");
    hw_reset_a: assert property (!resetting && hwFall
                                 |=> resetting ##0 seqCnt_q == 13'h0000)
        else $error("reset pin edge ignored");
    sw_reset_a: assert property (!resetting && swEdge |=> resetting)
        else $error("soft reset key ignored");
    reset_default_a: assert property (resetting |=> pdCtrl_q == pdr_pkg::PD_CTRL_RESET
                                      && dacDriveEn_q == 8'h00)
        else $error("defaults not restored");
    reset_time_a: assert property (resetting && seqCnt_q == LAST_CNT |=> !resetting)
        else $error("reset overran its time");
    reset_count_a: assert property (resetting |-> seqCnt_q <= LAST_CNT)
        else $error("reset counter out of range");
    apply_cause_a: assert property (pdCtrl_q != $past(pdCtrl_q)
                                    |-> $past(applyCause))
        else $error("register changed without complete write");

    hw_reset_c: cover property (!resetting && hwFall ##1 resetting);
    sw_reset_c: cover property (!resetting && swEdge ##1 resetting);
    shutdown_c: cover property (wrEdge ##1 shutdown);
    temp_wake_c: cover property (adcChannelMask == 8'h00 && tempReadReq ##1 adcPowerUp_q);

endmodule // pdr_power_reset_ctrl
`default_nettype wire

/* File: verification/pdr_i2c_host.sv */
`timescale 1ns/1ps
`default_nettype none
module pdr_i2c_host (
    // Bus lines
    output logic       scl,
    output logic       sdaPullLow,
    input  wire logic  sda
);
    // ------------------------------------------------------------
    // Idle bus
    // ------------------------------------------------------------
    initial
    begin
        scl        = 1'b1;
        sdaPullLow = 1'b0;
    end

    // ------------------------------------------------------------
    // Byte with acknowledge slot, 160 ns bit time
    // ------------------------------------------------------------
    task automatic put_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--)
        begin
            sdaPullLow = ~b[i];
            #40 scl = 1'b1;
            #80 scl = 1'b0;
            #40;
        end
        sdaPullLow = 1'b0;
        #40 scl = 1'b1;
        #40 ack = ~sda;
        #40 scl = 1'b0;
        #40;
    endtask

    // ------------------------------------------------------------
    // Write frame of n bytes, then stop and leave the clock idle
    // ------------------------------------------------------------
    task automatic frame(input int n, input logic [7:0] adr, input logic [7:0] ptr,
                         input logic [15:0] data, output logic [3:0] acks);
        logic [7:0] b [4];
        b    = '{adr, ptr, data[15:8], data[7:0]};
        acks = 4'h0;
        sdaPullLow = 1'b1;
        #80 scl = 1'b0;
        #40;
        for (int i = 0; i < n; i++)
            put_byte(b[i], acks[i]);
        sdaPullLow = 1'b1;
        #40 scl = 1'b1;
        #80 sdaPullLow = 1'b0;
        #160; // Clock stays high and still after the frame
    endtask
endmodule // pdr_i2c_host
`default_nettype wire

/* File: verification/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam int RST_CYC = 40;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        resetPinN = 1'b1;
    logic [7:0]  dacMask = 8'h00;
    logic [7:0]  adcMask = 8'h00;
    logic        tempReq = 1'b0;
    logic        scl;
    logic        hostLow;
    logic        sdaOut;
    logic        sdaOe;
    wire logic   sda = ~((sdaOe & ~sdaOut) | hostLow);
    logic [15:0] pdCtrl;
    logic [7:0]  dacSleep;
    logic [7:0]  dacDriveEn;
    logic        refEnable;
    logic        adcPowerUp;
    logic        resetBusy;
    int          errors = 0;
    int          compares = 0;
    int          busyRun = 0;
    int          busyLen = 0;
    logic [7:0]  adrW;
    logic [15:0] d;
    logic [15:0] corner [3];
    int          n;

    always #10 clk = ~clk;

    // Length of the last reset pulse, counted from its first cycle
    always @(posedge clk)
    begin
        if (resetBusy === 1'b1)
            busyRun <= busyRun + 1;
        else if (busyRun > 0)
        begin
            busyLen <= busyRun;
            busyRun <= 0;
        end
    end

    pdr_power_reset_ctrl #(.RESET_CYCLES(RST_CYC)) u_pdr_power_reset_ctrl (
        .clk(clk), .rst_n(rst_n), .scl(scl), .sdaIn(sda), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .resetPinN(resetPinN), .dacChannelMask(dacMask),
        .adcChannelMask(adcMask), .tempReadReq(tempReq), .pdCtrl(pdCtrl),
        .dacSleep(dacSleep), .dacDriveEn(dacDriveEn), .refEnable(refEnable),
        .adcPowerUp(adcPowerUp), .resetBusy(resetBusy)
    );

    pdr_i2c_host u_pdr_i2c_host (.scl(scl), .sdaPullLow(hostLow), .sda(sda));

    // ------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input logic [17:0] got, input logic [17:0] exp);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [17:0] exp_power(input logic [15:0] v);
        logic       sd;
        logic [7:0] sl;
        sd = v[pdr_pkg::SHUTDOWN_BIT];
        sl = sd ? 8'hFF : (v[7:0] & dacMask);
        return {~sd & v[pdr_pkg::REF_EN_BIT], ~sd & ((|adcMask) | tempReq), sl, dacMask & ~sl};
    endfunction

    task automatic check_state(input logic [15:0] v);
        check({2'h0, pdCtrl}, {2'h0, v});
        check({refEnable, adcPowerUp, dacSleep, dacDriveEn}, exp_power(v));
    endtask

    task automatic wr(input int nb, input logic [7:0] adr, input logic [7:0] ptr,
                      input logic [15:0] v, input logic [3:0] expAck);
        logic [3:0] acks;
        u_pdr_i2c_host.frame(nb, adr, ptr, v, acks);
        check({14'h0, acks}, {14'h0, expAck});
        repeat (3) @(negedge clk);
    endtask

    task automatic wait_reset(output int cnt);
        for (int i = 0; i < 300 && resetBusy !== 1'b0; i++)
            @(posedge clk);
        repeat (2) @(posedge clk);
        cnt = busyLen;
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(3376));
        adrW   = {pdr_pkg::DEV_ADDR, 1'b0};
        corner = '{16'h06FF, 16'h02FF, 16'h0000};
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        check_state(16'h0000);
        check({17'h0, sdaOut}, 18'h0);
        for (int i = 0; i < 11; i++)
        begin
            dacMask = 8'($urandom);
            adcMask = ($urandom % 3 == 0) ? 8'h00 : 8'(($urandom));
            tempReq = (i == 2) ? 1'b1 : 1'($urandom);
            d = (i < 3) ? corner[i] : 16'($urandom) & pdr_pkg::PD_WRITE_MASK;
            wr(4, adrW, pdr_pkg::PTR_PD_CTRL, d, 4'hF);
            check_state(d);
        end
        d = 16'h0281;
        wr(4, adrW, pdr_pkg::PTR_PD_CTRL, d, 4'hF);
        wr(3, adrW, pdr_pkg::PTR_PD_CTRL, 16'h0400, 4'h7);
        check_state(d);
        wr(4, adrW, 8'h0C, 16'h0400, 4'hF);
        wr(4, 8'h22, pdr_pkg::PTR_PD_CTRL, 16'h0400, 4'h0);
        wr(4, adrW, pdr_pkg::PTR_SOFT_RESET, 16'h0DAD, 4'hF);
        check({17'h0, resetBusy}, 18'h0);
        check_state(d);
        u_pdr_i2c_host.frame(4, adrW, pdr_pkg::PTR_SOFT_RESET, pdr_pkg::SOFT_RESET_KEY, d[3:0]);
        check({14'h0, d[3:0]}, 18'h7);
        check({17'h0, resetBusy}, 18'h1);
        wait_reset(n); // Host stays idle until done
        check(18'(n), 18'(RST_CYC));
        check_state(16'h0000);
        d = 16'h0455;
        wr(4, adrW, pdr_pkg::PTR_PD_CTRL, d, 4'hF);
        check_state(d);
        resetPinN = 1'b0;
        repeat (3) @(negedge clk);
        resetPinN = 1'b1; // Pin high outside reset requests
        check({17'h0, resetBusy}, 18'h1);
        wait_reset(n);
        check(18'(n), 18'(RST_CYC));
        check_state(16'h0000);
        tally_and_finish();
    end

    initial
    begin
        #500000;
        errors++;
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire
